// ### rtl/slrx_pkg.sv
// Constants, field layouts and carrier types for the serial link receiver
// configuration bank.
// Assumes one 100 MHz clock, a synchronous active-high reset, and byte-wide
// register access at the printed offsets.
//
// How it works
// [RULE1] Software changes config only while link disabled
// [RULE2] Bit 6 selects vendor transmitter compatibility
// [RULE3] Class 0: release once all lanes write
// [RULE4] Class 1: release at delayed multiframe opportunity
// [RULE5] Bit 4 selects 8b/10b or 64b/66b
// [RULE6] Bit 1 picks offset binary or two's complement
// [RULE7] Bit 0 enables 8b/10b descrambling, resets one
// [RULE8] 64b/66b always descrambles, scrambler bit ignored
// [RULE9] Both ends should scramble in 8b/10b
// [RULE10] Link control resets to 03h
// [RULE11] Sync word mode matters only in 64b/66b
// [RULE12] Mode zero checks CRC-12 per multiblock
// [RULE13] Received command fields are always ignored
// [RULE14] Multiframe length holds frames minus one, reset 31
// [RULE15] Software programs a legal frames per multiframe
// [RULE16] 64b/66b frames per multiframe is 256*E/F
// [RULE17] Reserved sync word modes must not be written
// [RULE18] Disabled link holds receiver and counter reset
// [RULE19] Each delay step moves release four octets
package slrx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] SLRX_OFF_LINK_CONTROL = 16'h0103;
  localparam logic [15:0] SLRX_OFF_SYNC_WORD    = 16'h0104;
  localparam logic [15:0] SLRX_OFF_MF_LENGTH    = 16'h0105;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] SLRX_RST_LINK_CONTROL = 8'h03;
  localparam logic [7:0] SLRX_RST_SYNC_WORD    = 8'h00;
  localparam logic [7:0] SLRX_RST_MF_LENGTH    = 8'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and masks
  localparam int unsigned SLRX_BIT_COMPAT   = 6;
  localparam int unsigned SLRX_BIT_RELCLASS = 5;
  localparam int unsigned SLRX_BIT_ENCODING = 4;
  localparam int unsigned SLRX_BIT_SAMPLE_FORMAT  = 1;
  localparam int unsigned SLRX_BIT_SCRAMBLE = 0;
  localparam logic [7:0]  SLRX_MASK_LINK_CONTROL = 8'h73;
  localparam logic [7:0]  SLRX_MASK_SYNC_WORD    = 8'h03;
  localparam logic [1:0]  SLRX_SYNC_MODE_CRC12   = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and link constants
  localparam int unsigned SLRX_LANES       = 16;
  localparam int unsigned SLRX_RBD_W       = 6;
  localparam int unsigned SLRX_MF_W        = 16;
  localparam int unsigned SLRX_OCTET_SHIFT = 2;
  localparam logic [SLRX_MF_W-1:0] SLRX_EMB_OCTETS = 16'h0100;

  typedef enum logic {
    SLRX_ENC_8B10B,
    SLRX_ENC_64B66B
  } slrx_enc_t;

  typedef enum logic [1:0] {
    SLRX_ST_OFF,
    SLRX_ST_WAIT,
    SLRX_ST_RELEASED
  } slrx_state_t;

  // Decoded configuration toward the link layer
  typedef struct packed {
    logic                 vendor_transmitter_compat;
    logic                 release_class;
    slrx_enc_t            link_encoding_select;
    logic                 sample_format;
    logic                 descramble_en;
    logic                 crc12_check_en;
    logic [SLRX_MF_W-1:0] frames_per_multiframe;
  } slrx_cfg_t;

  // Byte-wide register access port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } slrx_req_t;

endpackage

// ### rtl/slrx_config.sv
// Configuration bank and elastic buffer release control of the serial link
// receiver.
// Assumes the multiframe counter, lane PHY and subsystem enable live outside
// and that all inputs are synchronous to clk_sys.
`timescale 1ns/1ps
module slrx_config (
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  input  wire logic                               ce,
  input  wire slrx_pkg::slrx_req_t                req,
  output      logic [7:0]                         rdata,
  output      logic                               rvalid,
  input  wire logic                               link_subsystem_enable,
  input  wire logic [slrx_pkg::SLRX_RBD_W-1:0]    release_buffer_delay,
  input  wire logic [slrx_pkg::SLRX_MF_W-1:0]     multiframe_clock_counter,
  input  wire logic [7:0]                         multiblocks_per_emb,
  input  wire logic [7:0]                         octets_per_frame,
  input  wire logic [slrx_pkg::SLRX_LANES-1:0]    lane_active,
  input  wire logic [slrx_pkg::SLRX_LANES-1:0]    lane_writing,
  output      slrx_pkg::slrx_cfg_t                cfg,
  output      logic                               buffer_release,
  output      logic                               rx_subsystem_reset,
  output      logic                               mf_counter_reset,
  output      logic                               phy_enable
);
  import slrx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]        link_control_reg;
  logic [7:0]        sync_word_reg;
  logic [7:0]        mf_length_reg;
  logic [7:0]        rdata_reg;
  logic              rvalid_reg;
  slrx_cfg_t         cfg_reg;
  slrx_cfg_t         cfg_next;
  slrx_state_t       state_reg;
  slrx_state_t       state_next;
  logic              release_reg;
  logic              hold_reg;

  // Effective frames per multiframe in 64b/66b: 256 * E / F
  function automatic logic [SLRX_MF_W-1:0] emb_frames(input logic [7:0] e,
                                                      input logic [7:0] f);
    logic [SLRX_MF_W-1:0] octets;
    octets = SLRX_EMB_OCTETS * {8'h00, e};
    if (f == 8'h00) begin
      emb_frames = octets;
    end else begin
      emb_frames = octets / {8'h00, f};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire hit_ctrl = req.addr == SLRX_OFF_LINK_CONTROL;
  wire hit_sync = req.addr == SLRX_OFF_SYNC_WORD;
  wire hit_mfl  = req.addr == SLRX_OFF_MF_LENGTH;

  wire [7:0] rd_mux = hit_ctrl ? link_control_reg :
                      hit_sync ? sync_word_reg :
                      hit_mfl  ? mf_length_reg : 8'h00;

  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_control_reg <= SLRX_RST_LINK_CONTROL; // [RULE10]
      sync_word_reg    <= SLRX_RST_SYNC_WORD; // [RULE12]
      mf_length_reg    <= SLRX_RST_MF_LENGTH; // [RULE14]
    end else if (ce && req.wr) begin
      if (hit_ctrl) begin
        link_control_reg <= req.wdata & SLRX_MASK_LINK_CONTROL;
      end
      if (hit_sync) begin
        sync_word_reg <= req.wdata & SLRX_MASK_SYNC_WORD;
      end
      if (hit_mfl) begin
        mf_length_reg <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      rvalid_reg <= req.rd;
      rdata_reg  <= req.rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  wire is_64b66b = link_control_reg[SLRX_BIT_ENCODING]; // [RULE5]
  wire [1:0] sync_mode = sync_word_reg[1:0];

  // Command fields of received sync words have no consumer here [RULE13]
  always_comb begin
    cfg_next = '0;
    cfg_next.vendor_transmitter_compat = link_control_reg[SLRX_BIT_COMPAT]; // [RULE2]
    cfg_next.release_class = link_control_reg[SLRX_BIT_RELCLASS];
    cfg_next.link_encoding_select = is_64b66b ? SLRX_ENC_64B66B : SLRX_ENC_8B10B; // [RULE5]
    cfg_next.sample_format = link_control_reg[SLRX_BIT_SAMPLE_FORMAT]; // [RULE6]
    // 64b/66b payload is always scrambled
    cfg_next.descramble_en = is_64b66b | link_control_reg[SLRX_BIT_SCRAMBLE]; // [RULE7] [RULE8]
    cfg_next.crc12_check_en = is_64b66b && (sync_mode == SLRX_SYNC_MODE_CRC12); // [RULE11] [RULE12]
    cfg_next.frames_per_multiframe = is_64b66b ?
      emb_frames(multiblocks_per_emb, octets_per_frame) : // [RULE16]
      {8'h00, mf_length_reg} + 16'h0001; // [RULE14]
  end

  // Registered so the divider settles off the link path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= '0;
    end else if (ce) begin
      cfg_reg <= cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Elastic buffer release
  wire all_started = ((lane_writing & lane_active) == lane_active) && (lane_active != '0);
  wire [SLRX_MF_W-1:0] release_point =
    {{(SLRX_MF_W-SLRX_RBD_W){1'b0}}, release_buffer_delay} << SLRX_OCTET_SHIFT; // [RULE19]
  wire opportunity = multiframe_clock_counter == release_point; // [RULE4]
  wire release_now = link_control_reg[SLRX_BIT_RELCLASS] ?
                     (all_started && opportunity) : all_started; // [RULE3] [RULE4]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLRX_ST_OFF: begin
        if (link_subsystem_enable) begin
          state_next = SLRX_ST_WAIT;
        end
      end
      SLRX_ST_WAIT: begin
        if (!link_subsystem_enable) begin
          state_next = SLRX_ST_OFF;
        end else if (release_now) begin
          state_next = SLRX_ST_RELEASED;
        end
      end
      SLRX_ST_RELEASED: begin
        if (!link_subsystem_enable) begin
          state_next = SLRX_ST_OFF;
        end
      end
      default: state_next = SLRX_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= SLRX_ST_OFF;
      release_reg <= 1'b0;
      hold_reg    <= 1'b1;
    end else if (ce) begin
      state_reg   <= state_next;
      release_reg <= state_next == SLRX_ST_RELEASED;
      hold_reg    <= !link_subsystem_enable; // [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata              = rdata_reg;
  assign rvalid             = rvalid_reg;
  assign cfg                = cfg_reg;
  assign buffer_release     = release_reg;
  assign rx_subsystem_reset = hold_reg;
  assign mf_counter_reset   = hold_reg;
  assign phy_enable         = !hold_reg;

endmodule

// ### test/slrx_tx_model.sv
// Far-side transmitter model: lanes start writing one by one, plus octet counter.
// Assumes phy_enable and mf_counter_reset come from the DUT.
`timescale 1ns/1ps
module slrx_tx_model (
  input  wire logic        clk_sys,
  input  wire logic        phy_enable,
  input  wire logic        mf_counter_reset,
  output      logic [15:0] lane_writing,
  output      logic [15:0] multiframe_clock_counter
);
  // Lanes come up skewed, one per cycle, so release waits on the slowest one
  always @(posedge clk_sys) begin
    lane_writing <= phy_enable ? {lane_writing[14:0], 1'b1} : 16'h0000;
    multiframe_clock_counter <= mf_counter_reset ? 16'h0000 :
      {8'h00, multiframe_clock_counter[7:0] + 8'h04};
  end
  initial lane_writing = 16'h0000;
  initial multiframe_clock_counter = 16'h0000;
endmodule

// ### test/slrx_config_assertions.sv
// Port checker for the configuration bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module slrx_config_chk (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire slrx_pkg::slrx_req_t   req,
  input wire logic                  link_subsystem_enable,
  input wire logic [5:0]            release_buffer_delay,
  input wire logic [15:0]           multiframe_clock_counter,
  input wire logic [7:0]            multiblocks_per_emb,
  input wire logic [7:0]            octets_per_frame,
  input wire logic [15:0]           lane_active,
  input wire logic [15:0]           lane_writing,
  input wire slrx_pkg::slrx_cfg_t   cfg,
  input wire logic                  buffer_release,
  input wire logic                  rx_subsystem_reset,
  input wire logic                  mf_counter_reset,
  input wire logic                  phy_enable
);
  import slrx_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wr_ctl = ce && req.wr && req.addr == 16'h0103;
  wire enc64 = cfg.link_encoding_select == SLRX_ENC_64B66B;
  hold_reset_a: assert property
    (ce && !link_subsystem_enable |=> rx_subsystem_reset && !phy_enable && !buffer_release)
    else $error("link not held off while disabled");
  run_free_a: assert property
    (ce && link_subsystem_enable |=> !mf_counter_reset && phy_enable)
    else $error("link held off while enabled");
  class0_rel_a: assert property
    ($rose(buffer_release) && !cfg.release_class |-> $past((lane_writing & lane_active) == lane_active))
    else $error("early release in class 0");
  class1_rel_a: assert property
    ($rose(buffer_release) && cfg.release_class |->
     $past(multiframe_clock_counter) == 16'({release_buffer_delay, 2'b00}))
    else $error("release off its opportunity");
  ctrl_fields_a: assert property
    (wr_ctl ##1 ce |=> {cfg.vendor_transmitter_compat, cfg.release_class, cfg.link_encoding_select,
     cfg.sample_format} == $past({req.wdata[6:4], req.wdata[1]}, 2))
    else $error("control fields not decoded");
  scr_write_a: assert property
    (wr_ctl && !req.wdata[4] ##1 ce |=> cfg.descramble_en == $past(req.wdata[0], 2))
    else $error("descramble enable wrong");
  always_descr_a: assert property (enc64 |-> cfg.descramble_en)
    else $error("64b66b not descrambled");
  emb_frames_a: assert property
    (enc64 |-> cfg.frames_per_multiframe == 16'h0100 * multiblocks_per_emb / octets_per_frame)
    else $error("64b66b frames wrong");
  cover property ($rose(buffer_release) && cfg.release_class);
  cover property ($rose(buffer_release) && !cfg.release_class);
  cover property (enc64);
endmodule
bind slrx_config slrx_config_chk u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req),
  .link_subsystem_enable(link_subsystem_enable), .release_buffer_delay(release_buffer_delay),
  .multiframe_clock_counter(multiframe_clock_counter), .multiblocks_per_emb(multiblocks_per_emb),
  .octets_per_frame(octets_per_frame), .lane_active(lane_active), .lane_writing(lane_writing),
  .cfg(cfg), .buffer_release(buffer_release), .rx_subsystem_reset(rx_subsystem_reset),
  .mf_counter_reset(mf_counter_reset), .phy_enable(phy_enable));

// ### test/serial_link_rx_config_tb.sv
// Testbench: register access, decoding and buffer release.
// Assumes the transmitter model and the bound checker.
`timescale 1ns/1ps
module serial_link_rx_config_tb;
  import slrx_pkg::*;
  logic clk_sys = 0, rst = 1, ce = 1, en = 0, rvalid, rel, rxr, mfr, phy;
  slrx_req_t req = '0;
  slrx_cfg_t cfg;
  logic [7:0] rdata, e_n = 8'h02, f_n = 8'h04;
  logic [5:0] dly = 0;
  logic [15:0] act = 16'h000f, lw, mfc;
  int failures = 0, compares = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  slrx_config DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
    .rvalid(rvalid), .link_subsystem_enable(en), .release_buffer_delay(dly),
    .multiframe_clock_counter(mfc), .multiblocks_per_emb(e_n), .octets_per_frame(f_n),
    .lane_active(act), .lane_writing(lw), .cfg(cfg), .buffer_release(rel),
    .rx_subsystem_reset(rxr), .mf_counter_reset(mfr), .phy_enable(phy));
  slrx_tx_model u_tx (.clk_sys(clk_sys), .phy_enable(phy), .mf_counter_reset(mfr),
    .lane_writing(lw), .multiframe_clock_counter(mfc));
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys) req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys) req.wr = 0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] x);
    @(negedge clk_sys) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys) req.rd = 0;
    chk("rdata", {rvalid, rdata}, {1'b1, x});
  endtask
  // Config is written only while disabled; release is awaited under a bound
  task go(input logic [7:0] c, input logic [15:0] a, input logic [5:0] d, input logic [15:0] m);
    int n;
    wr(16'h0103, c);
    act = a;
    dly = d;
    en = 1;
    for (n = 0; n < 200 && rel !== 1'b1; n++) @(negedge clk_sys);
    chk("lanes", lw & act, act);
    if (c[5]) chk("counter", mfc, m);
    en = 0;
    @(negedge clk_sys);
    chk("hold", {rel, rxr, mfr, phy}, 4'b0110);
    $display("release test done");
  endtask
  always @(posedge clk_sys) if (++cyc > 3000) begin
    failures++;
    test_done;
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 0;
    rd(16'h0103, 8'h03);
    rd(16'h0104, 8'h00);
    rd(16'h0105, 8'h1f);
    chk("reset cfg", {cfg.frames_per_multiframe, cfg.descramble_en}, {16'd32, 1'b1});
    chk("fmt crc", {cfg.sample_format, cfg.crc12_check_en}, 2'b10);
    $display("reset test done");
    wr(16'h0103, 8'hff);
    rd(16'h0103, 8'h73);
    wr(16'h0104, 8'hff);
    rd(16'h0104, 8'h03);
    wr(16'h0106, 8'h55);
    rd(16'h0106, 8'h00);
    wr(16'h0104, 8'h00);
    wr(16'h0105, 8'h0f);
    for (int i = 0; i < 8; i++) begin
      wr(16'h0103, {3'b000, i[2], 2'b00, i[1:0]});
      @(negedge clk_sys);
      chk("descramble", cfg.descramble_en, i[0] | i[2]);
      chk("format", cfg.sample_format, i[1]);
      chk("frames", cfg.frames_per_multiframe, i[2] ? 16'd128 : 16'd16);
      chk("crc", cfg.crc12_check_en, i[2]);
    end
    $display("decode test done");
    go(8'h03, 16'h000f, 6'd0, 16'd0);
    go(8'h23, 16'hffff, 6'd5, 16'd24);
    test_done;
  end
endmodule
